// file: src/cfe_regs.svh
// Constants of the frame error diagnostic status word and its serial port.
// Definitions only; included by the design files.
`ifndef CFE_REGS_SVH
`define CFE_REGS_SVH

`define CFE_ADDR_DIAG5      6'h15
`define CFE_OP_READ_CLEAR   2'h3
`define CFE_CMD_BITS        5'h08
`define CFE_FRAME_BITS      5'h18
`define CFE_CNT_MAX         5'h1F
`define CFE_CNT_ZERO        5'h00
`define CFE_CNT_ONE         5'h01
`define CFE_FEC_MSB         12
`define CFE_FEC_LSB         8
`define CFE_OSC_FAIL_BIT    7
`define CFE_OSC_MON_MSB     4
`define CFE_OSC_MON_LSB     0
`define CFE_WORD_RESET      16'h0000
`define CFE_MON_RESET       5'h00

`endif

// file: src/cfe_pkg.sv
// Types shared by the frame error diagnostic status block.
// Assumes nothing of its surroundings.
package cfe_pkg;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_CMD  = 4'b0010,
        S_DATA = 4'b0100,
        S_DONE = 4'b1000
    } cfe_spi_e;

endpackage

// file: src/cfe_sync.sv
// Two-flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none

module cfe_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,    // System clock
    input  wire logic             arst_n, // Async reset, active low
    input  wire logic [WIDTH-1:0] d,      // Asynchronous inputs
    input  wire logic [WIDTH-1:0] rst_val,// Constant level held in reset
    output logic      [WIDTH-1:0] q       // Synchronised outputs
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Reset constants come from tie-offs at the instance
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d ^ rst_val;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q ^ rst_val;
endmodule

`default_nettype wire

// file: src/cfe_status_top.sv
// Frame error diagnostic status word with its serial control port slave.
// Assumes frame and oscillator events come from logic on clk; the serial
// pins come from outside and are synchronised first.
// What this block does
// - Command address 010101 selects the word; bytes 15..8 then 7..0.
// - Five-bit frame error count sits in bits 12..8, LSB at 8.
// - Erroneous frame (CRC, stuff, form) adds one to the count.
// - A correctly decoded frame with no erroneous frame in that cycle subtracts one from a nonzero count.
// - Error at count 31: wake, set frame-detect error, count to 0.
// - Oscillator failure flag in bit 7 held until read-and-clear.
// - Oscillator monitor bits 4..0 refreshed after each sent frame.
// - Count field refreshed as live value after each sent frame.
// - Frame-detect error flag latched until read-and-clear of neighbour.
// - System error is NOT all read-done OR osc failure OR frame-detect error flag.
// - System error blocks and clears the selective wake enable.
`timescale 1ns/10ps
`default_nettype none
`include "cfe_regs.svh"

module cfe_status_top
    import cfe_pkg::*;
#(
    parameter int RD_BITS = 9
) (
    input  wire logic               clk,            // 125 MHz clock
    input  wire logic               arst_n,         // Async reset
    input  wire logic               spi_sclk,       // Serial clock pin
    input  wire logic               spi_csn,        // Chip select pin
    input  wire logic               spi_mosi,       // Serial data in pin
    output logic                    spi_miso_o,     // Serial data out
    output logic                    spi_miso_oe,    // Data out enable
    input  wire logic               frame_ok,       // Good frame pulse
    input  wire logic               frame_err,      // Bad frame pulse
    input  wire logic               frame_sent,     // Frame sent pulse
    input  wire logic               osc_fail_event, // Osc failure pulse
    input  wire logic [4:0]         osc_mon_in,     // Osc monitor live
    input  wire logic [RD_BITS-1:0] wake_register_read_done, // Done bits
    input  wire logic               frame_detect_error_bit_clear,   // Neighbour rd-clear
    input  wire logic               selective_wake_enable_wr,       // Wake enable write
    input  wire logic               selective_wake_enable_wdata,    // Wake enable value
    output logic                    frame_detect_error_bit, // Flag
    output logic                    wake_system_error,      // Sys error
    output logic                    selective_wake_enable,  // Enable
    output logic                    wake_up_q       // Wake pulse
);
    // Synchronised pins
    logic [2:0] pins_s;
    logic       sclk_s;
    logic       csn_s;
    logic       mosi_s;

    cfe_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .d       ({spi_sclk, spi_csn, spi_mosi}),
        .rst_val (3'h2),
        .q       (pins_s)
    );

    assign sclk_s = pins_s[2];
    assign csn_s  = pins_s[1];
    assign mosi_s = pins_s[0];

    logic       sclk_prev_q;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_active;

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;
    assign cs_active = ~csn_s;

    // Frame error counter and visible fields
    logic [4:0]  count_q;
    logic [4:0]  count_d;
    logic [4:0]  fec_field_q;
    logic [4:0]  osc_mon_q;
    logic        osc_fail_q;
    logic        frame_detect_error_bit_q;
    logic        overflow;

    assign overflow = frame_err & (count_q == `CFE_CNT_MAX);
    assign count_d  = overflow ? `CFE_CNT_ZERO :
                      frame_err ? count_q + `CFE_CNT_ONE :
                      (frame_ok && count_q != `CFE_CNT_ZERO) ?
                          count_q - `CFE_CNT_ONE :
                      count_q;

    // Serial port state
    cfe_spi_e   state_q;
    cfe_spi_e   state_d;
    logic [4:0] bit_q;
    logic [7:0] cmd_q;
    logic [15:0] shift_q;
    logic [15:0] status_word;
    logic       addr_hit;
    logic       rd_clear_done;
    logic       cmd_complete;

    // Reserved positions stay zero
    always_comb
    begin
        status_word = `CFE_WORD_RESET;
        status_word[`CFE_FEC_MSB:`CFE_FEC_LSB] = fec_field_q;
        status_word[`CFE_OSC_FAIL_BIT] = osc_fail_q;
        status_word[`CFE_OSC_MON_MSB:`CFE_OSC_MON_LSB] = osc_mon_q;
    end

    assign addr_hit = (cmd_q[5:0] == `CFE_ADDR_DIAG5);
    assign cmd_complete = sclk_rise & (bit_q == `CFE_CMD_BITS - 5'h01);
    // Clear only after a whole 24-bit transfer, so an aborted frame
    // cannot lose a failure the host never saw
    assign rd_clear_done = csn_s & (state_q == S_DONE) & addr_hit &
                           (cmd_q[7:6] == `CFE_OP_READ_CLEAR);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (cs_active)
                    state_d = S_CMD;
            S_CMD:
                if (csn_s)
                    state_d = S_IDLE;
                else if (cmd_complete)
                    state_d = S_DATA;
            S_DATA:
                if (csn_s)
                    state_d = S_IDLE;
                else if (sclk_rise &&
                         bit_q == `CFE_FRAME_BITS - 5'h01)
                    state_d = S_DONE;
            S_DONE:
                if (csn_s)
                    state_d = S_IDLE;
            default:
                state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q     <= S_IDLE;
            sclk_prev_q <= 1'b0;
            bit_q       <= 5'h00;
            cmd_q       <= 8'h00;
            shift_q     <= `CFE_WORD_RESET;
            spi_miso_o  <= 1'b0;
            spi_miso_oe <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            sclk_prev_q <= sclk_s;
            spi_miso_oe <= cs_active;
            if (csn_s)
                bit_q <= 5'h00;
            else if (sclk_rise && state_q != S_DONE)
                bit_q <= bit_q + 5'h01;
            if (sclk_rise && state_q == S_CMD)
                cmd_q <= {cmd_q[6:0], mosi_s};
            // Word is captured once so both bytes come from one instant
            if (cmd_complete && state_q == S_CMD)
                shift_q <= ({cmd_q[4:0], mosi_s} == `CFE_ADDR_DIAG5) ?
                           status_word : `CFE_WORD_RESET;
            else if (sclk_fall && state_q == S_DATA)
            begin
                spi_miso_o <= shift_q[15];
                shift_q    <= {shift_q[14:0], 1'b0};
            end
            else if (csn_s)
                spi_miso_o <= 1'b0;
        end
    end

    // Status and counter flops
    logic wake_system_error_d;
    logic selective_wake_enable_d;

    assign wake_system_error_d = ~(&wake_register_read_done) | osc_fail_q |
                       frame_detect_error_bit_q;
    assign selective_wake_enable_d = wake_system_error_d ? 1'b0 :
                     selective_wake_enable_wr ? selective_wake_enable_wdata : selective_wake_enable;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_q                <= `CFE_CNT_ZERO;
            fec_field_q            <= `CFE_CNT_ZERO;
            osc_mon_q              <= `CFE_MON_RESET;
            osc_fail_q             <= 1'b0;
            frame_detect_error_bit_q               <= 1'b0;
            frame_detect_error_bit <= 1'b0;
            wake_system_error      <= 1'b1;
            selective_wake_enable  <= 1'b0;
            wake_up_q              <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            // Snapshot includes the frame event of the same cycle
            if (frame_sent)
            begin
                fec_field_q <= count_d;
                osc_mon_q   <= osc_mon_in;
            end
            // Set wins over clear
            if (osc_fail_event)
                osc_fail_q <= 1'b1;
            else if (rd_clear_done)
                osc_fail_q <= 1'b0;
            if (overflow)
                frame_detect_error_bit_q <= 1'b1;
            else if (frame_detect_error_bit_clear)
                frame_detect_error_bit_q <= 1'b0;
            frame_detect_error_bit <= overflow | (frame_detect_error_bit_q & ~frame_detect_error_bit_clear);
            wake_up_q              <= overflow;
            wake_system_error      <= wake_system_error_d;
            selective_wake_enable  <= selective_wake_enable_d;
        end
    end
endmodule

`default_nettype wire

// file: bench/cfe_status_top_chk.sv
// Port checker for the diagnostic status block.
// Assumes one clock domain and the reset of the top module.
`timescale 1ns/10ps
`default_nettype none

module cfe_status_top_chk #(
    parameter int RD_BITS = 9
) (
    input wire logic               clk,                     // Clock
    input wire logic               arst_n,                  // Reset
    input wire logic               spi_csn,                 // Select
    input wire logic               spi_miso_oe,             // Out enable
    input wire logic               frame_err,               // Bad frame
    input wire logic               frame_detect_error_bit_clear,            // Flag clear
    input wire logic               selective_wake_enable_wr,                // Enable wr
    input wire logic               selective_wake_enable_wdata,             // Enable val
    input wire logic [RD_BITS-1:0] wake_register_read_done, // Done bits
    input wire logic               frame_detect_error_bit,  // Flag
    input wire logic               wake_system_error,       // Sys error
    input wire logic               selective_wake_enable,   // Enable
    input wire logic               wake_up_q                // Wake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_wake_flag; wake_up_q |-> frame_detect_error_bit; endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake no flag");
    property p_wake_one; wake_up_q |=> !wake_up_q; endproperty
    a_wake_one: assert property (p_wake_one) else $error("wake too long");
    property p_wake_cause; wake_up_q |-> $past(frame_err); endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake cause");
    property p_fd_sys; frame_detect_error_bit |=> wake_system_error; endproperty
    a_fd_sys: assert property (p_fd_sys) else $error("flag no syserr");
    property p_rd_sys; !(&wake_register_read_done) |=> wake_system_error;
    endproperty
    a_rd_sys: assert property (p_rd_sys) else $error("done no syserr");
    property p_sys_en; wake_system_error |-> !selective_wake_enable;
    endproperty
    a_sys_en: assert property (p_sys_en) else $error("enable kept");
    property p_fd_clr; $fell(frame_detect_error_bit) |-> $past(frame_detect_error_bit_clear);
    endproperty
    a_fd_clr: assert property (p_fd_clr) else $error("flag lost");
    property p_en_set;
        $rose(selective_wake_enable) |-> $past(selective_wake_enable_wr) &&
                                         $past(selective_wake_enable_wdata);
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable cause");
    property p_oe_idle; spi_csn [*5] |-> !spi_miso_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
endmodule

bind cfe_status_top cfe_status_top_chk #(
    .RD_BITS (RD_BITS)
) u_chk (
    .clk                     (clk),
    .arst_n                  (arst_n),
    .spi_csn                 (spi_csn),
    .spi_miso_oe             (spi_miso_oe),
    .frame_err               (frame_err),
    .frame_detect_error_bit_clear            (frame_detect_error_bit_clear),
    .selective_wake_enable_wr                (selective_wake_enable_wr),
    .selective_wake_enable_wdata             (selective_wake_enable_wdata),
    .wake_register_read_done (wake_register_read_done),
    .frame_detect_error_bit  (frame_detect_error_bit),
    .wake_system_error       (wake_system_error),
    .selective_wake_enable   (selective_wake_enable),
    .wake_up_q               (wake_up_q)
);

`default_nettype wire

// file: bench/cfe_host_model.sv
// Host controller model driving the serial control port.
// Assumes mode 0 timing; miso is resolved by the bench.
`timescale 1ns/10ps
`default_nettype none

module cfe_host_model (
    input  wire logic clk,  // System clock
    input  wire logic miso, // Resolved data line
    output var  logic sclk, // Serial clock
    output var  logic csn,  // Chip select
    output var  logic mosi  // Serial data
);
    // Slow phases so miso settles after its sync delay
    localparam int PH = 6;
    initial
    begin
        sclk = 1'b0;
        csn  = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input logic [7:0] cmd, output logic [15:0] d);
        @(posedge clk) csn <= 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            mosi <= (i < 8) ? cmd[7-i] : 1'b0;
            repeat (PH) @(posedge clk);
            sclk <= 1'b1;
            if (i >= 8) d[23-i] = miso;
            repeat (PH) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (PH) @(posedge clk);
        csn <= 1'b1;
        repeat (PH) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// file: bench/cfe_status_top_tb.sv
// Self-checking bench for the diagnostic status block.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
`default_nettype none

module cfe_status_top_tb;
    logic clk = 0, arst_n = 0, fe = 0, fo = 0, fs = 0, of = 0;
    logic fdc = 0, swr = 0, swd = 0, oe, mo, fdb, sys, swe, wq;
    logic sclk, csn, mosi;
    logic [4:0] mon = 5'h00;
    logic [8:0] rd = 9'h1FF;
    logic [15:0] w;
    int failures = 0, n_compared = 0, cyc = 0;
    // Released line shows the inverse so a stale bit cannot pass
    wire logic miso = oe ? mo : ~mo;

    cfe_host_model host (.clk(clk), .miso(miso), .sclk(sclk), .csn(csn),
        .mosi(mosi));
    cfe_status_top uut (.clk(clk), .arst_n(arst_n), .spi_sclk(sclk),
        .spi_csn(csn), .spi_mosi(mosi), .spi_miso_o(mo), .spi_miso_oe(oe),
        .frame_ok(fo), .frame_err(fe), .frame_sent(fs),
        .osc_fail_event(of), .osc_mon_in(mon),
        .wake_register_read_done(rd), .frame_detect_error_bit_clear(fdc), .selective_wake_enable_wr(swr),
        .selective_wake_enable_wdata(swd), .frame_detect_error_bit(fdb),
        .wake_system_error(sys), .selective_wake_enable(swe),
        .wake_up_q(wq));

    initial forever #4 clk = ~clk;

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic ev(input logic [3:0] v, input int n);
        {fe, fo, fs, of} <= v;
        repeat (n) @(posedge clk);
        {fe, fo, fs, of} <= 4'h0;
        @(posedge clk);
    endtask
    task automatic en(input logic v);
        swr <= 1'b1;
        swd <= v;
        @(posedge clk) swr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rdw(input logic [7:0] c, input logic [15:0] e);
        host.xfer(c, w);
        chk(w, e);
    endtask
    task automatic finish_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            failures++;
            finish_test;
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({sys, fdb, swe, wq}, 16'h0000);
        rdw(8'h15, 16'h0000);
        $display("reset test done");
        ev(4'h8, 5);
        ev(4'h4, 2);
        rdw(8'h15, 16'h0000);
        mon <= 5'h15;
        ev(4'h2, 1);
        rdw(8'h15, 16'h0315);
        ev(4'h4, 5);
        ev(4'hA, 1);
        rdw(8'h15, 16'h0115);
        $display("count test done");
        ev(4'h1, 1);
        rdw(8'h15, 16'h0195);
        rdw(8'hD5, 16'h0195);
        rdw(8'h15, 16'h0115);
        $display("osc test done");
        ev(4'h8, 30);
        fe <= 1'b1;
        @(posedge clk) fe <= 1'b0;
        // Wake pulse and frame-detect flag both stand in the cycle after the overflow
        #1 chk({wq, fdb}, 16'h0003);
        @(posedge clk);
        ev(4'h2, 1);
        rdw(8'h15, 16'h0015);
        $display("overflow test done");
        en(1'b1);
        chk(swe, 16'h0000);
        fdc <= 1'b1;
        @(posedge clk) fdc <= 1'b0;
        repeat (3) @(posedge clk);
        chk({sys, fdb}, 16'h0000);
        en(1'b1);
        chk(swe, 16'h0001);
        rd <= 9'h1FE;
        repeat (3) @(posedge clk);
        chk({sys, swe}, 16'h0002);
        rd <= 9'h1FF;
        rdw(8'h16, 16'h0000);
        $display("wake test done");
        finish_test;
    end
endmodule

`default_nettype wire
